/* logic/cfg_guard_params.svh */
// Constants for the configuration access guard: offsets, fields, reset values and timing.
`ifndef CFG_GUARD_PARAMS_SVH
`define CFG_GUARD_PARAMS_SVH
`define ADDR_SCRATCH_0 7'h06
`define ADDR_SCRATCH_3 7'h09
`define ADDR_LOCK 7'h0a
`define ADDR_NV_STATUS 7'h70
`define ADDR_STARTUP 7'h73
`define ADDR_SBC_CFG 7'h74
`define ADDR_CHECKSUM 7'h75
`define ADDR_PART_ID 7'h7e
`define ADDR_SYS_EVENT 7'h61
`define CRC_POLY 8'h2f
`define CRC_INIT 8'hff
`define CRC_XOR 8'hff
`define LOCK_MASK 8'h7f
`define STARTUP_PRESET 8'h00
`define SBC_CFG_PRESET 8'h04
`define SERIAL_FAILURE_FLAG_BIT 1
`define PO_BIT 4
`define RESTORE_DELAY_US 1000
`define RESTORE_CYCLES ((`RESTORE_DELAY_US * 1000) / 10)
`define WRCNT_MAX 6'h3f
`define PROG_CYCLES 16
`endif

/* logic/cfg_guard_pkg.sv */
// Types shared by the configuration access guard.
package cfg_guard_pkg;
    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_RESTORE,
        ST_SYSRESET,
        ST_FORCED_NORMAL,
        ST_PROGRAM
    } guard_state_t;
endpackage

/* logic/cfg_access_guard.sv */
// SPI register slave with write locks, scratch RAM, NV checksum and preset restore.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_guard_params.svh"
// Contract
// - Checksum covers the two bytes at 0x73 and 0x74.
// - CRC is 8 bit, polynomial 0x2f, no reflection.
// - CRC starts at 0xff and the result is inverted.
// - Byte 0x73 first, each XORed in then shifted eight times MSB first.
// - Programming starts only on checksum match, else request is dropped.
// - Presets restore when reset low, CANH high, CANL low for delay.
// - After restore, system reset then forced normal mode.
// - Receive output high during restore, falls once power-on flag sets.
// - Write counter increments on each preset restore; the code saturates it at 0x3f and also counts each programming.
// - Read-only identification byte at 0x7e.
// - Locks block SPI writes only; internal status updates continue.
// - Lock bits 6,5,4 guard 0x68-0x6f, 0x50-0x5f, 0x40-0x4f.
// - Lock bits 3,2,1 guard 0x30-0x3f, 0x20-0x2f, 0x10-0x1f.
// - Lock bit 0 guards scratch bytes; bit 7 reads zero.
// - Four scratch RAM bytes at 0x06 to 0x09.
// - SPI is full duplex, register data out while data comes in.
// - Read-only mode returns registers without changing them.
// - Chip select active low, clock idles low.
// - Data output released whenever chip select is high.
// - Sample on falling clock edge, shift out on rising edge.
// - First byte is 7 bit address then read flag in LSB.
// - Write with bit count not 16, 24 or 32 aborts and flags failure.
module cfg_access_guard #(
    parameter int RESTORE_CYCLES = `RESTORE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic serial_select_low,
    input wire logic spi_clk,
    input wire logic spi_data_in,
    output logic spi_data_out,
    output logic spi_data_oe,
    input wire logic reset_pin_low_active,
    input wire logic canh_at_battery,
    input wire logic canl_at_ground,
    output logic can_receive_output,
    output logic system_reset_req,
    output cfg_guard_pkg::guard_state_t guard_state,
    output logic programming_busy
);
    import cfg_guard_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [2:0] cs_sync_ff, clk_sync_ff, din_sync_ff, rst_sync_ff, ch_sync_ff, cl_sync_ff;
    logic cs_q_ff, sck_q_ff;

    // Three stages each; a level counts once stages two and three agree, except data in, which is taken from stage three alone.
    always_ff @(posedge ref_clk) begin
        cs_sync_ff <= {cs_sync_ff[1:0], serial_select_low};
        clk_sync_ff <= {clk_sync_ff[1:0], spi_clk};
        din_sync_ff <= {din_sync_ff[1:0], spi_data_in};
        rst_sync_ff <= {rst_sync_ff[1:0], reset_pin_low_active};
        ch_sync_ff <= {ch_sync_ff[1:0], canh_at_battery};
        cl_sync_ff <= {cl_sync_ff[1:0], canl_at_ground};
    end

    // Filtered levels hold their last agreed value while stages disagree.
    wire cs_agree = cs_sync_ff[2] == cs_sync_ff[1];
    wire sck_agree = clk_sync_ff[2] == clk_sync_ff[1];
    wire cs_lvl = cs_agree ? cs_sync_ff[2] : cs_q_ff;
    wire sck_lvl = sck_agree ? clk_sync_ff[2] : sck_q_ff;
    wire din_lvl = din_sync_ff[2];
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cs_q_ff <= 1'b1;
            sck_q_ff <= 1'b0;
        end else begin
            cs_q_ff <= cs_lvl;
            sck_q_ff <= sck_lvl;
        end
    end

    // Edge strobes of the serial link in the core clock.
    wire frame_on = !cs_lvl;
    wire sck_fall = sck_q_ff && !sck_lvl && frame_on;
    wire sck_rise = !sck_q_ff && sck_lvl && frame_on;
    wire frame_end = !cs_q_ff && cs_lvl;
    wire frame_start = cs_q_ff && !cs_lvl;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] scratch_ff [4];
    logic [6:0] lock_ff;
    logic [7:0] startup_ff, sbc_cfg_ff, checksum_ff, sys_event_ff;
    logic [5:0] wrcnt_ff;
    localparam logic [7:0] PART_ID = 8'h5a; // Arbitrary neutral identification value.

    // ****************************************************************
    // Serial shifter
    // ****************************************************************
    logic [5:0] bit_cnt_ff;
    logic [7:0] shift_in_ff, shift_out_ff;
    logic [6:0] addr_ff;
    logic read_only_ff;
    logic [7:0] pend_data_ff [3];
    logic [1:0] pend_cnt_ff;

    // Read mux; the counter field and flags sit in the status byte.
    logic [7:0] rd_data;
    wire [6:0] rd_addr;
    wire scratch_hit = rd_addr >= `ADDR_SCRATCH_0 && rd_addr <= `ADDR_SCRATCH_3;
    wire [1:0] scratch_idx = 2'(rd_addr - `ADDR_SCRATCH_0);
    always_comb begin
        rd_data = 8'h00;
        if (scratch_hit) rd_data = scratch_ff[scratch_idx];
        else if (rd_addr == `ADDR_LOCK) rd_data = {1'b0, lock_ff};
        else if (rd_addr == `ADDR_SYS_EVENT) rd_data = sys_event_ff;
        else if (rd_addr == `ADDR_NV_STATUS) rd_data = {wrcnt_ff, 2'b01};
        else if (rd_addr == `ADDR_STARTUP) rd_data = startup_ff;
        else if (rd_addr == `ADDR_SBC_CFG) rd_data = sbc_cfg_ff;
        else if (rd_addr == `ADDR_CHECKSUM) rd_data = checksum_ff;
        else if (rd_addr == `ADDR_PART_ID) rd_data = PART_ID;
    end

    // Address of the byte being returned: first data byte is the addressed one.
    wire [7:0] next_in = {shift_in_ff[6:0], din_lvl};
    wire byte_done = sck_fall && bit_cnt_ff[2:0] == 3'd7;
    wire [1:0] data_idx = 2'(bit_cnt_ff[5:3] - 3'd1);
    assign rd_addr = (bit_cnt_ff[5:3] == 3'd0) ? next_in[7:1] : 7'(addr_ff + 7'(data_idx) + 7'd1);

    // Bits are sampled on falling edges and counted per frame.
    always_ff @(posedge ref_clk) begin
        if (reset || frame_start) begin
            bit_cnt_ff <= 6'd0;
            shift_in_ff <= 8'h00;
        end else if (sck_fall) begin
            shift_in_ff <= next_in;
            if (bit_cnt_ff != 6'h3f) bit_cnt_ff <= bit_cnt_ff + 6'd1;
        end
    end

    // The header byte latches address and read flag; data bytes queue until frame end.
    always_ff @(posedge ref_clk) begin
        if (reset || frame_start) begin
            addr_ff <= 7'h00;
            read_only_ff <= 1'b1;
            pend_cnt_ff <= 2'd0;
        end else if (byte_done && bit_cnt_ff[5:3] == 3'd0) begin
            addr_ff <= next_in[7:1];
            read_only_ff <= next_in[0];
        end else if (byte_done && bit_cnt_ff[5:3] <= 3'd3) begin
            pend_data_ff[data_idx] <= next_in;
            pend_cnt_ff <= 2'(data_idx + 2'd1);
        end
    end

    // Output byte loads at each byte boundary, shifts on rising edges; past 32 bits input echoes.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shift_out_ff <= 8'h00;
        end else if (frame_start) begin
            shift_out_ff <= sys_event_ff;
        end else if (byte_done) begin
            shift_out_ff <= (bit_cnt_ff >= 6'd31) ? next_in : rd_data;
        end else if (sck_rise && bit_cnt_ff[2:0] != 3'd0) begin
            shift_out_ff <= {shift_out_ff[6:0], 1'b0};
        end
    end

    // Pin driven only inside a frame.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            spi_data_out <= 1'b0;
            spi_data_oe <= 1'b0;
        end else begin
            spi_data_out <= shift_out_ff[7];
            spi_data_oe <= frame_on;
        end
    end

    // ****************************************************************
    // Write commit and lock decode
    // ****************************************************************
    wire count_ok = bit_cnt_ff == 6'd16 || bit_cnt_ff == 6'd24 || bit_cnt_ff == 6'd32;
    wire commit = frame_end && !read_only_ff && count_ok;
    wire spi_fail = frame_end && !read_only_ff && !count_ok;
    logic [2:0] wr_hit [3];
    logic [7:0] wr_free;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_wr
            wire [6:0] a = 7'(addr_ff + 7'(g));
            wire lk = (a >= 7'h68 && a <= 7'h6f && lock_ff[6]) ||
                      (a[6:4] == 3'h5 && lock_ff[5]) || (a[6:4] == 3'h4 && lock_ff[4]) ||
                      (a[6:4] == 3'h3 && lock_ff[3]) || (a[6:4] == 3'h2 && lock_ff[2]) ||
                      (a[6:4] == 3'h1 && lock_ff[1]) ||
                      (a >= `ADDR_SCRATCH_0 && a <= `ADDR_SCRATCH_3 && lock_ff[0]);
            wire en = commit && 2'(g) < pend_cnt_ff && !lk;
            assign wr_hit[g] = {en && a == `ADDR_CHECKSUM, en && a == `ADDR_SBC_CFG,
                                en && a == `ADDR_STARTUP};
            assign wr_free[g] = en;
        end
    endgenerate
    assign wr_free[7:3] = 5'h00;

    // ****************************************************************
    // Checksum over the two configuration bytes
    // ****************************************************************
    function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] din);
        logic [7:0] d;
        d = crc ^ din;
        for (int j = 0; j < 8; j++) begin
            d = d[7] ? ({d[6:0], 1'b0} ^ `CRC_POLY) : {d[6:0], 1'b0};
        end
        return d;
    endfunction
    wire [7:0] crc_expect = crc_byte(crc_byte(`CRC_INIT, startup_ff), sbc_cfg_ff) ^ `CRC_XOR;

    // ****************************************************************
    // Power-up restore and programming sequencer
    // ****************************************************************
    guard_state_t state_ff, nxt_state;
    logic [$clog2(RESTORE_CYCLES+1)-1:0] dly_ff;
    logic [4:0] prog_ff;
    logic checksum_wr_ff;
    // Each pin counts only once its second and third stages agree, so a glitch cannot start the wait.
    wire restore_cond = !rst_sync_ff[2] && !rst_sync_ff[1] && ch_sync_ff[2] && ch_sync_ff[1] &&
                        cl_sync_ff[2] && cl_sync_ff[1];
    wire dly_done = dly_ff == ($bits(dly_ff))'(RESTORE_CYCLES);
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_POWERUP: if (dly_done) nxt_state = ST_RESTORE;
                else if (!restore_cond) nxt_state = ST_FORCED_NORMAL;
            ST_RESTORE: nxt_state = ST_SYSRESET;
            ST_SYSRESET: nxt_state = ST_FORCED_NORMAL;
            ST_FORCED_NORMAL: if (checksum_wr_ff && checksum_ff == crc_expect) nxt_state = ST_PROGRAM;
            ST_PROGRAM: if (prog_ff == 5'(`PROG_CYCLES)) nxt_state = ST_SYSRESET;
            default: nxt_state = ST_FORCED_NORMAL;
        endcase
    end

    // Sequencer state, delay and programming timers.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff <= ST_POWERUP;
            dly_ff <= '0;
            prog_ff <= 5'd0;
        end else begin
            state_ff <= nxt_state;
            dly_ff <= (state_ff == ST_POWERUP && restore_cond && !dly_done) ? dly_ff + 1'b1 : '0;
            prog_ff <= (state_ff == ST_PROGRAM) ? prog_ff + 5'd1 : 5'd0;
        end
    end

    // Checksum is judged one cycle after its write; a mismatch just drops the request.
    always_ff @(posedge ref_clk) begin
        if (reset) checksum_wr_ff <= 1'b0;
        else checksum_wr_ff <= |{wr_hit[0][2], wr_hit[1][2], wr_hit[2][2]};
    end

    // Configuration bytes, checksum, counter; restore is internal and ignores locks.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            startup_ff <= `STARTUP_PRESET;
            sbc_cfg_ff <= `SBC_CFG_PRESET;
            checksum_ff <= 8'h00;
            wrcnt_ff <= 6'h00;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (wr_hit[k][0]) startup_ff <= pend_data_ff[k];
                if (wr_hit[k][1]) sbc_cfg_ff <= pend_data_ff[k];
                if (wr_hit[k][2]) checksum_ff <= pend_data_ff[k];
            end
            if (state_ff == ST_RESTORE) begin
                startup_ff <= `STARTUP_PRESET;
                sbc_cfg_ff <= `SBC_CFG_PRESET;
                if (wrcnt_ff != `WRCNT_MAX) wrcnt_ff <= wrcnt_ff + 6'd1;
            end else if (state_ff == ST_PROGRAM && nxt_state == ST_SYSRESET &&
                         wrcnt_ff != `WRCNT_MAX) begin
                wrcnt_ff <= wrcnt_ff + 6'd1;
            end
        end
    end

    // Scratch bytes and lock register via SPI; event byte writes clear with set winning.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lock_ff <= 7'h00;
            sys_event_ff <= 8'h00;
            for (int k = 0; k < 4; k++) scratch_ff[k] <= 8'h00;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (wr_free[k] && 7'(addr_ff + 7'(k)) == `ADDR_LOCK)
                    lock_ff <= pend_data_ff[k][6:0];
                if (wr_free[k] && 7'(addr_ff + 7'(k)) == `ADDR_SYS_EVENT)
                    sys_event_ff <= sys_event_ff & ~pend_data_ff[k];
                if (wr_free[k] && 7'(addr_ff + 7'(k)) >= `ADDR_SCRATCH_0 &&
                    7'(addr_ff + 7'(k)) <= `ADDR_SCRATCH_3)
                    scratch_ff[2'(addr_ff + 7'(k) - `ADDR_SCRATCH_0)] <= pend_data_ff[k];
            end
            if (spi_fail) sys_event_ff[`SERIAL_FAILURE_FLAG_BIT] <= 1'b1;
            if (state_ff == ST_SYSRESET) sys_event_ff[`PO_BIT] <= 1'b1;
        end
    end

    // Status outputs; receive output is held high through the restore.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            can_receive_output <= 1'b1;
            system_reset_req <= 1'b0;
            guard_state <= ST_POWERUP;
            programming_busy <= 1'b0;
        end else begin
            can_receive_output <= (state_ff == ST_POWERUP || state_ff == ST_RESTORE) ||
                                  !sys_event_ff[`PO_BIT];
            system_reset_req <= state_ff == ST_SYSRESET;
            guard_state <= state_ff;
            programming_busy <= state_ff == ST_PROGRAM;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    restore_then_reset_a: assert property (state_ff == ST_RESTORE |=> state_ff == ST_SYSRESET ##1 state_ff == ST_FORCED_NORMAL) else $error("restore not followed by reset");
    bad_crc_drop_a: assert property (checksum_wr_ff && checksum_ff != crc_expect && state_ff == ST_FORCED_NORMAL |=> state_ff != ST_PROGRAM) else $error("bad checksum started programming");
    count_on_restore_a: assert property (state_ff == ST_RESTORE && wrcnt_ff != `WRCNT_MAX |=> wrcnt_ff == $past(wrcnt_ff) + 6'd1) else $error("counter missed restore");
    serial_failure_flag_on_bad_a: assert property (spi_fail |=> sys_event_ff[`SERIAL_FAILURE_FLAG_BIT]) else $error("failure flag not set");
    lock_bit7_zero_a: assert property (rd_addr == `ADDR_LOCK |-> rd_data[7] == 1'b0) else $error("lock bit 7 not zero");
    id_read_a: assert property (rd_addr == `ADDR_PART_ID |-> rd_data == PART_ID) else $error("identifier wrong");
    sdo_release_a: assert property (cs_lvl |=> !spi_data_oe) else $error("data output driven while deselected");
    rxd_high_restore_a: assert property (state_ff == ST_RESTORE |=> can_receive_output) else $error("receive output low in restore");
    read_no_change_a: assert property (frame_end && read_only_ff |=> $stable(scratch_ff[0]) && $stable(lock_ff)) else $error("read modified register");
    scratch_locked_a: assert property (lock_ff[0] |=> $stable(scratch_ff[0]) && $stable(scratch_ff[3])) else $error("locked scratch byte changed");
    cover_restore_c: cover property (state_ff == ST_RESTORE);
    cover_program_c: cover property (state_ff == ST_PROGRAM);
    cover_fail_c: cover property (spi_fail);
    cover_commit_c: cover property (commit && pend_cnt_ff == 2'd3);
endmodule // cfg_access_guard
`default_nettype wire

/* tb/spi_master_model.sv */
// Microcontroller model that masters the serial register port of the guard.
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
    output var logic serial_select_low,
    output var logic spi_clk,
    output var logic spi_data_in,
    input wire logic spi_data_out,
    input wire logic spi_data_oe
);
    // Idle levels: deselected, clock parked low as the pull-down would hold it.
    initial begin
        serial_select_low = 1'b1;
        spi_clk = 1'b0;
        spi_data_in = 1'b0;
    end

    // One frame of nbits, MSB first from tx[31]; the answer lands in rx[nbits-1:0].
    // The clock runs only inside the frame, 125 ns a bit, unrelated to the core clock.
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = '0;
        serial_select_low = 1'b0;
        #200;
        for (int i = 0; i < nbits; i++) begin
            spi_clk = 1'b1;
            spi_data_in = tx[31 - i];
            #62.5;
            spi_clk = 1'b0;
            rx = {rx[30:0], (spi_data_oe === 1'b1) ? spi_data_out : 1'bx};
            #62.5;
        end
        #200;
        serial_select_low = 1'b1;
        // The data line is not held after the frame, so the last bit is never reused.
        spi_data_in = ~spi_data_in;
        #200;
    endtask
endmodule // spi_master_model
`default_nettype wire

/* tb/sbc_config_access_guard_tb_top.sv */
// Self-checking bench for the configuration access guard.
`timescale 1ns/100ps
`default_nettype none
module sbc_config_access_guard_tb_top;
    import cfg_guard_pkg::*;
    localparam int restore_len = 20;
    // Arbitrary part code chosen for the design, not a real product value.
    localparam logic [7:0] part_id_expected = 8'h5a;
    logic ref_clk, reset, reset_pin_low_active, canh_at_battery, canl_at_ground;
    wire logic serial_select_low, spi_clk, spi_data_in, spi_data_out, spi_data_oe;
    logic can_receive_output, system_reset_req, programming_busy;
    guard_state_t guard_state;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int resets_seen = 0;
    int busy_cycles = 0;
    logic [31:0] rx;
    logic [7:0] ev, crc;

    cfg_access_guard #(.RESTORE_CYCLES(restore_len)) u_dut (.ref_clk(ref_clk), .reset(reset),
        .serial_select_low(serial_select_low), .spi_clk(spi_clk), .spi_data_in(spi_data_in),
        .spi_data_out(spi_data_out), .spi_data_oe(spi_data_oe),
        .reset_pin_low_active(reset_pin_low_active), .canh_at_battery(canh_at_battery),
        .canl_at_ground(canl_at_ground), .can_receive_output(can_receive_output),
        .system_reset_req(system_reset_req), .guard_state(guard_state),
        .programming_busy(programming_busy));
    spi_master_model u_master (.serial_select_low(serial_select_low), .spi_clk(spi_clk),
        .spi_data_in(spi_data_in), .spi_data_out(spi_data_out), .spi_data_oe(spi_data_oe));

    // ********************************
    // Clock, watchdog and event counts
    // ********************************
    always #5 ref_clk = ~ref_clk;
    // A hang is cut short well above the roughly 8400 cycles the tests need.
    always @(posedge ref_clk) begin
        cycles++;
        if (system_reset_req === 1'b1) resets_seen++;
        if (programming_busy === 1'b1) busy_cycles++;
        if (cycles == 30000) begin
            num_errors++;
            $display("unexpected at %0t: run did not finish in time", $time);
            give_verdict();
        end
    end

    // **********************
    // Access and check tasks
    // **********************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_master.xfer({a, 1'b0, d, 16'h0000}, 16, rx);
    endtask
    // Reads one register; the event byte that leads every answer is left in ev.
    task automatic rd_check(input logic [6:0] a, input logic [7:0] exp, input string what);
        u_master.xfer({a, 1'b1, 24'h000000}, 16, rx);
        ev = rx[15:8];
        check(rx[7:0], exp, what);
        check({7'h00, spi_data_oe}, 8'h00, "output released after frame");
    endtask
    task automatic wait_state(input guard_state_t s, input int limit);
        int n;
        n = 0;
        while (guard_state !== s && n < limit) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check({5'h00, guard_state}, {5'h00, s}, "sequencer state");
    endtask
    // Reference checksum, worked bit by bit from the polynomial and the two given bytes.
    function automatic logic [7:0] nv_crc(input logic [7:0] b0, input logic [7:0] b1);
        logic [15:0] src;
        logic [7:0] c;
        src = {b0, b1};
        c = 8'hff;
        for (int i = 0; i < 2; i++) begin
            c = c ^ src[15 - 8 * i -: 8];
            for (int j = 0; j < 8; j++) begin
                c = c[7] ? ({c[6:0], 1'b0} ^ 8'h2f) : {c[6:0], 1'b0};
            end
        end
        return c ^ 8'hff;
    endfunction

    // *************
    // Main sequence
    // *************
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        reset_pin_low_active = 1'b0;
        canh_at_battery = 1'b1;
        canl_at_ground = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (restore_len - 2) @(posedge ref_clk);
        #1 check({5'h00, guard_state}, {5'h00, ST_POWERUP}, "restore too early");
        wait_state(ST_RESTORE, 10);
        check({7'h00, can_receive_output}, 8'h01, "receive output during restore");
        wait_state(ST_FORCED_NORMAL, 10);
        repeat (3) @(posedge ref_clk);
        #1 check({7'h00, can_receive_output}, 8'h00, "receive output after restore");
        check(resets_seen[7:0], 8'h01, "system reset pulses");
        reset_pin_low_active = 1'b1;
        canh_at_battery = 1'b0;
        canl_at_ground = 1'b0;
        rd_check(7'h70, 8'h05, "write counter after restore");
        check(ev & 8'h10, 8'h10, "power-on flag");
        wr(7'h61, 8'h10);
        $display("test power-up restore done");
        rd_check(7'h7e, part_id_expected, "part code");
        wr(7'h7e, 8'h00);
        rd_check(7'h7e, part_id_expected, "part code after write");
        $display("test identification done");
        u_master.xfer({7'h06, 1'b0, 24'h112233}, 32, rx);
        wr(7'h09, 8'h44);
        u_master.xfer({7'h06, 1'b1, 24'h000000}, 32, rx);
        check(rx[23:16], 8'h11, "scratch 0");
        check(rx[15:8], 8'h22, "scratch 1");
        check(rx[7:0], 8'h33, "scratch 2");
        rd_check(7'h09, 8'h44, "scratch 3");
        u_master.xfer({7'h06, 1'b1, 24'hee0000}, 16, rx);
        rd_check(7'h06, 8'h11, "read frame left data");
        $display("test scratch memory done");
        wr(7'h0a, 8'hff);
        rd_check(7'h0a, 8'h7f, "lock register");
        wr(7'h06, 8'haa);
        rd_check(7'h06, 8'h11, "locked scratch");
        check(ev & 8'h02, 8'h00, "no failure on locked write");
        wr(7'h0a, 8'h00);
        rd_check(7'h0a, 8'h00, "lock cleared");
        $display("test locks done");
        for (int n = 8; n <= 31; n += 11) begin
            u_master.xfer({7'h06, 1'b0, 24'hee5566}, n, rx);
            rd_check(7'h06, 8'h11, "aborted write");
            check(ev & 8'h02, 8'h02, "failure flag");
            wr(7'h61, 8'h02);
        end
        $display("test bit counts done");
        wr(7'h73, 8'ha5);
        wr(7'h74, 8'h3c);
        crc = nv_crc(8'ha5, 8'h3c);
        wr(7'h75, crc ^ 8'h01);
        check(busy_cycles[7:0], 8'h00, "programming on bad checksum");
        wr(7'h75, crc);
        // Programming and the reset that ends it outlast the frame's closing gap.
        repeat (10) @(posedge ref_clk);
        #1 check(busy_cycles[7:0], 8'h11, "programming on good checksum");
        check(resets_seen[7:0], 8'h02, "reset after programming");
        $display("test checksum done");
        give_verdict();
    end
endmodule // sbc_config_access_guard_tb_top
`default_nettype wire
